// ===== design/acc_ctrl.v
// Converter control: registers, sequencing, calibration, averaging, gain and offset correction
`timescale 1ns/100ps
`include "acc_map.vh"
module acc_ctrl (
  input wire clk_sys,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  input wire hw_trigger,
  input wire stop_mode,
  output reg conv_start,
  output reg conv_abort,
  input wire conv_done,
  input wire [15:0] conv_raw,
  output reg cal_start,
  input wire cal_done,
  output reg [1:0] vref_select,
  output reg [15:0] plus_gain_core,
  output reg result_strobe
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 2'b00;
  localparam ST_CONV = 2'b01;
  localparam ST_CAL = 2'b10;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg hw_trigger_sel_q;
  reg compare_func_en_q;
  reg compare_greater_sel_q;
  reg compare_range_en_q;
  reg [1:0] vref_source_sel_q;
  reg selftune_failed_q;
  reg selftune_failed_d;
  reg continuous_conv_q;
  reg average_on_q;
  reg [1:0] average_count_sel_q;
  reg [15:0] offset_q;
  reg [15:0] plus_gain_q;
  reg [15:0] cv1_q;
  reg [15:0] cv2_q;
  reg [15:0] result_value_q;
  reg [2:0] mode_q;
  reg ready_q;
  reg ready_d;
  reg [22:0] acc_q;
  reg [4:0] cnt_q;

  // ----------------------------------------
  // Register access and state decode
  // ----------------------------------------
  wire wr_cmp = reg_wr && (reg_addr == `ACC_OFS_CMP_CTRL);
  wire wr_cal = reg_wr && (reg_addr == `ACC_OFS_CAL_CTRL);
  wire wr_start = reg_wr && (reg_addr == `ACC_OFS_MODE_START);
  wire rd_res_lo = reg_rd && (reg_addr == `ACC_OFS_RES_LO);
  wire in_cal = (state_q == ST_CAL);
  wire in_conv = (state_q == ST_CONV);

  // Calibration runs to its end once started; a second start is ignored
  wire cal_go = wr_cal && reg_wdata[`ACC_BIT_CAL] && !in_cal;
  wire sw_go = wr_start && !hw_trigger_sel_q && !in_cal && !cal_go;
  // A calibration start in the same cycle wins, so no stray start pulse reaches the core
  wire hw_go = hw_trigger && hw_trigger_sel_q && (state_q == ST_IDLE) && !cal_go;
  wire trig_go = sw_go || hw_go;

  // ----------------------------------------
  // Mode properties
  // ----------------------------------------
  // Mode code bit 0 marks the signed differential modes
  wire signed_mode = mode_q[0];
  reg [4:0] mode_bits;
  always @* begin
    case (mode_q)
      3'h0: mode_bits = 5'h10;
      3'h1: mode_bits = 5'h10;
      3'h2: mode_bits = 5'h0C;
      3'h3: mode_bits = 5'h0D;
      3'h4: mode_bits = 5'h0A;
      3'h5: mode_bits = 5'h0B;
      3'h6: mode_bits = 5'h08;
      default: mode_bits = 5'h09;
    endcase
  end
  wire [4:0] offs_shift = 5'h10 - mode_bits;

  // ----------------------------------------
  // Gain correction
  // ----------------------------------------
  // Single-ended: whole sample scaled here; differential: factor goes to the core
  wire [31:0] gain_prod = conv_raw * plus_gain_q;
  wire signed [17:0] sample_se = {1'b0, gain_prod[31:15]};
  wire signed [17:0] sample_df = {{2{conv_raw[15]}}, conv_raw};
  wire signed [17:0] sample = signed_mode ? sample_df : sample_se;

  // ----------------------------------------
  // Averaging
  // ----------------------------------------
  wire signed [22:0] acc_sum = $signed(acc_q) + {{5{sample[17]}}, sample};
  wire [4:0] last_cnt = {average_count_sel_q == 2'h3, average_count_sel_q[1],
                         average_count_sel_q != 2'h0, 2'b11};
  wire set_end = !average_on_q || (cnt_q == last_cnt);
  wire [2:0] avg_shift = {1'b0, average_count_sel_q} + 3'h2;
  wire signed [22:0] acc_mean = acc_sum >>> avg_shift;
  wire signed [17:0] mean = average_on_q ? acc_mean[17:0] : sample;

  // ----------------------------------------
  // Offset correction and saturation
  // ----------------------------------------
  // Offset is scaled down from full 16-bit justification to the mode width
  wire signed [15:0] offs_al = $signed(offset_q) >>> offs_shift;
  wire signed [18:0] corr = {mean[17], mean} - {{3{offs_al[15]}}, offs_al};
  wire [18:0] one19 = 19'h00001;
  wire [4:0] mag_bits = mode_bits - {4'h0, signed_mode};
  wire signed [18:0] lim_max = $signed((one19 << mag_bits) - one19);
  wire signed [18:0] lim_min = signed_mode ? -$signed(one19 << mag_bits) : 19'sh00000;
  reg [15:0] sat_value;
  always @* begin
    if (corr > lim_max) begin
      sat_value = lim_max[15:0];
    end else if (corr < lim_min) begin
      sat_value = lim_min[15:0];
    end else begin
      sat_value = corr[15:0];
    end
  end

  // ----------------------------------------
  // Compare
  // ----------------------------------------
  // Eight-bit single-ended mode ignores the high compare byte
  wire [15:0] cv1_use = (mode_q == `ACC_MODE_8B_SE) ? {8'h00, cv1_q[7:0]} : cv1_q;
  wire [15:0] cv2_use = (mode_q == `ACC_MODE_8B_SE) ? {8'h00, cv2_q[7:0]} : cv2_q;
  wire cmp_match;
  acc_cmp u_cmp (
    .result_value(sat_value),
    .compare_value_first(cv1_use),
    .compare_value_second(cv2_use),
    .signed_mode(signed_mode),
    .compare_func_en(compare_func_en_q),
    .compare_greater_sel(compare_greater_sel_q),
    .compare_range_en(compare_range_en_q),
    .match(cmp_match)
  );

  wire done_set = in_conv && conv_done && set_end && !cal_go && !sw_go;
  wire store = done_set && cmp_match;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cal_go) begin
          state_d = ST_CAL;
        end else if (trig_go) begin
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (cal_go) begin
          state_d = ST_CAL;
        end else if (done_set && !continuous_conv_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_CAL: begin
        if (cal_done) begin
          state_d = ST_IDLE;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // A register write in the very start cycle is the start itself, not a fault
  wire cal_fault = in_cal && (hw_trigger_sel_q || reg_wr || stop_mode);
  always @* begin
    selftune_failed_d = selftune_failed_q;
    if (wr_cal && reg_wdata[`ACC_BIT_CAL_FAIL]) begin
      selftune_failed_d = 1'b0;
    end
    if (cal_fault) begin
      selftune_failed_d = 1'b1;
    end
  end

  always @* begin
    ready_d = ready_q;
    if (rd_res_lo) begin
      ready_d = 1'b0;
    end
    if (store) begin
      ready_d = 1'b1;
    end
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      selftune_failed_q <= 1'b0;
      ready_q <= 1'b0;
      acc_q <= 23'h000000;
      cnt_q <= 5'h00;
      conv_start <= 1'b0;
      conv_abort <= 1'b0;
      cal_start <= 1'b0;
      result_value_q <= 16'h0000;
      result_strobe <= 1'b0;
    end else begin
      state_q <= state_d;
      selftune_failed_q <= selftune_failed_d;
      ready_q <= ready_d;
      cal_start <= cal_go;
      conv_abort <= in_conv && (cal_go || sw_go);
      conv_start <= trig_go || (in_conv && conv_done && !cal_go && !sw_go
                    && (!set_end || continuous_conv_q));
      result_strobe <= store;
      if (store) begin
        result_value_q <= sat_value;
      end
      if (cal_go || trig_go || (in_conv && conv_done && set_end)) begin
        acc_q <= 23'h000000;
        cnt_q <= 5'h00;
      end else if (in_conv && conv_done) begin
        acc_q <= acc_sum;
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // ----------------------------------------
  // Software-written registers
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hw_trigger_sel_q <= 1'b0;
      compare_func_en_q <= 1'b0;
      compare_greater_sel_q <= 1'b0;
      compare_range_en_q <= 1'b0;
      vref_source_sel_q <= 2'h0;
      continuous_conv_q <= 1'b0;
      average_on_q <= 1'b0;
      average_count_sel_q <= 2'h0;
      offset_q <= `ACC_RST_OFFS;
      plus_gain_q <= `ACC_RST_GAIN;
      cv1_q <= `ACC_RST_CV;
      cv2_q <= `ACC_RST_CV;
      mode_q <= 3'h0;
    end else if (reg_wr) begin
      case (reg_addr)
        `ACC_OFS_CMP_CTRL: begin
          hw_trigger_sel_q <= reg_wdata[`ACC_BIT_HW_TRIG];
          compare_func_en_q <= reg_wdata[`ACC_BIT_CMP_EN];
          compare_greater_sel_q <= reg_wdata[`ACC_BIT_CMP_GT];
          compare_range_en_q <= reg_wdata[`ACC_BIT_CMP_REN];
          vref_source_sel_q <= reg_wdata[1:0];
        end
        `ACC_OFS_CAL_CTRL: begin
          continuous_conv_q <= reg_wdata[`ACC_BIT_CONT];
          average_on_q <= reg_wdata[`ACC_BIT_AVG_EN];
          average_count_sel_q <= reg_wdata[1:0];
        end
        `ACC_OFS_OFFS_HI: offset_q[15:8] <= reg_wdata;
        `ACC_OFS_OFFS_LO: offset_q[7:0] <= reg_wdata;
        `ACC_OFS_GAIN_HI: plus_gain_q[15:8] <= reg_wdata;
        `ACC_OFS_GAIN_LO: plus_gain_q[7:0] <= reg_wdata;
        `ACC_OFS_CV1_HI: cv1_q[15:8] <= reg_wdata;
        `ACC_OFS_CV1_LO: cv1_q[7:0] <= reg_wdata;
        `ACC_OFS_CV2_HI: cv2_q[15:8] <= reg_wdata;
        `ACC_OFS_CV2_LO: cv2_q[7:0] <= reg_wdata;
        `ACC_OFS_MODE_START: mode_q <= reg_wdata[2:0];
        default: mode_q <= mode_q;
      endcase
    end
  end

  // ----------------------------------------
  // Core-facing outputs
  // ----------------------------------------
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      vref_select <= `ACC_VREF_DEFAULT;
      plus_gain_core <= `ACC_RST_GAIN;
    end else begin
      if (vref_source_sel_q == `ACC_VREF_RESERVED) begin
        vref_select <= `ACC_VREF_DEFAULT;
      end else begin
        vref_select <= vref_source_sel_q;
      end
      // The core only uses this for the plus input of differential conversions
      plus_gain_core <= plus_gain_q;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  reg [7:0] rd_mux;
  always @* begin
    case (reg_addr)
      `ACC_OFS_CMP_CTRL: rd_mux = {in_conv, hw_trigger_sel_q, compare_func_en_q,
                                   compare_greater_sel_q, compare_range_en_q, 1'b0, vref_source_sel_q};
      `ACC_OFS_CAL_CTRL: rd_mux = {in_cal, selftune_failed_q, 2'b00, continuous_conv_q,
                                   average_on_q, average_count_sel_q};
      `ACC_OFS_OFFS_HI: rd_mux = offset_q[15:8];
      `ACC_OFS_OFFS_LO: rd_mux = offset_q[7:0];
      `ACC_OFS_GAIN_HI: rd_mux = plus_gain_q[15:8];
      `ACC_OFS_GAIN_LO: rd_mux = plus_gain_q[7:0];
      `ACC_OFS_CV1_HI: rd_mux = cv1_q[15:8];
      `ACC_OFS_CV1_LO: rd_mux = cv1_q[7:0];
      `ACC_OFS_CV2_HI: rd_mux = cv2_q[15:8];
      `ACC_OFS_CV2_LO: rd_mux = cv2_q[7:0];
      `ACC_OFS_RES_HI: rd_mux = result_value_q[15:8];
      `ACC_OFS_RES_LO: rd_mux = result_value_q[7:0];
      `ACC_OFS_MODE_START: rd_mux = {5'h00, mode_q};
      `ACC_OFS_STATUS: rd_mux = {7'h00, ready_q};
      default: rd_mux = 8'h00;
    endcase
  end

  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rd_mux;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule // acc_ctrl

// ===== design/acc_map.vh
// Register map, field positions, reset values and mode codes of the converter control block
//
// Summary of operation
// - Greater-select low: less-than, or exclusive outside/inside range, per range enable.
// - Greater-select high: greater-or-equal, or inclusive outside/inside range matches.
// - Range enable low: result compared against the first compare value only.
// - Range enable high: result checked between or outside both compare values.
// - Greater and range settings matter only while compare function is enabled.
// - Reference select: 00 default, 01 alternate, 10 bandgap, 11 default.
// - Writing 1 to calibration start runs calibration; bit reads 1 until done.
// - Starting calibration aborts any conversion in progress.
// - Calibration fails on hardware trigger select, any register write, or stop mode.
// - Failed flag clears only by writing 1; writing 0 leaves it.
// - Continuous low gives one conversion or set; high repeats after trigger.
// - Averaging enable combines successive conversions; otherwise each is reported.
// - Averaging count codes 00..11 select 4, 8, 16 or 32 conversions.
// - Offset is signed left-justified 16 bits, high byte and low byte registers.
// - Offset is subtracted from each conversion and stored as the result.
// - Corrected value saturates to the limits of the current conversion mode.
// - Plus gain applies to positive input in differential, whole conversion single-ended.
// - Plus gain is 16-bit fixed point, binary point below the top bit.
// - Compare function enable, bit 5, turns the comparison on or off.
`ifndef ACC_MAP_VH
`define ACC_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACC_OFS_CMP_CTRL 4'h0
`define ACC_OFS_CAL_CTRL 4'h1
`define ACC_OFS_OFFS_HI 4'h2
`define ACC_OFS_OFFS_LO 4'h3
`define ACC_OFS_GAIN_HI 4'h4
`define ACC_OFS_GAIN_LO 4'h5
`define ACC_OFS_CV1_HI 4'h6
`define ACC_OFS_CV1_LO 4'h7
`define ACC_OFS_CV2_HI 4'h8
`define ACC_OFS_CV2_LO 4'h9
`define ACC_OFS_RES_HI 4'hA
`define ACC_OFS_RES_LO 4'hB
`define ACC_OFS_MODE_START 4'hC
`define ACC_OFS_STATUS 4'hD

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ACC_BIT_ACTIVE 7
`define ACC_BIT_HW_TRIG 6
`define ACC_BIT_CMP_EN 5
`define ACC_BIT_CMP_GT 4
`define ACC_BIT_CMP_REN 3
`define ACC_BIT_CAL 7
`define ACC_BIT_CAL_FAIL 6
`define ACC_BIT_CONT 3
`define ACC_BIT_AVG_EN 2

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define ACC_RST_CTRL 8'h00
`define ACC_RST_OFFS 16'h0000
`define ACC_RST_GAIN 16'h8000
`define ACC_RST_CV 16'h0000
`define ACC_VREF_DEFAULT 2'h0
`define ACC_VREF_RESERVED 2'h3
`define ACC_MODE_8B_SE 3'h6

`endif

// ===== design/acc_cmp.v
// Result compare unit of the converter control block
`timescale 1ns/100ps
module acc_cmp (
  input wire [15:0] result_value,
  input wire [15:0] compare_value_first,
  input wire [15:0] compare_value_second,
  input wire signed_mode,
  input wire compare_func_en,
  input wire compare_greater_sel,
  input wire compare_range_en,
  output reg match
);

  // ----------------------------------------
  // Extend to a common signed width
  // ----------------------------------------
  wire signed [16:0] res_x = {signed_mode & result_value[15], result_value};
  wire signed [16:0] cv1_x = {signed_mode & compare_value_first[15], compare_value_first};
  wire signed [16:0] cv2_x = {signed_mode & compare_value_second[15], compare_value_second};
  wire ordered = (cv1_x <= cv2_x);

  // ----------------------------------------
  // Match selection
  // ----------------------------------------
  always @* begin
    match = 1'b1;
    if (compare_func_en) begin
      case ({compare_greater_sel, compare_range_en})
        2'b00: match = (res_x < cv1_x);
        2'b10: match = (res_x >= cv1_x);
        2'b01: begin
          if (ordered) begin
            match = (res_x < cv1_x) || (res_x > cv2_x);
          end else begin
            match = (res_x < cv1_x) && (res_x > cv2_x);
          end
        end
        default: begin
          if (ordered) begin
            match = (res_x >= cv1_x) && (res_x <= cv2_x);
          end else begin
            match = (res_x >= cv1_x) || (res_x <= cv2_x);
          end
        end
      endcase
    end
  end

endmodule // acc_cmp

// ===== test/acc_ctrl_monitor.sv
// Assertion checker for the converter control block
`timescale 1ns/100ps
module acc_ctrl_monitor (
  input wire clk_sys,
  input wire reset,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire hw_trigger,
  input wire stop_mode,
  input wire conv_start,
  input wire conv_abort,
  input wire conv_done,
  input wire [15:0] conv_raw,
  input wire cal_start,
  input wire cal_done,
  input wire [1:0] vref_select,
  input wire [15:0] plus_gain_core,
  input wire result_strobe
);
  // ----------------------------------------
  // Shadow state
  // ----------------------------------------
  // Busy starts one cycle after the design's, so the bench keeps that cycle quiet
  reg cal_q, pend_q, hw_q, cont_q, avg_q, fail_q;
  wire wr_ctrl = reg_wr && reg_addr == 4'h0;
  wire wr_cal = reg_wr && reg_addr == 4'h1;
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      {cal_q, pend_q, hw_q, cont_q, avg_q, fail_q} <= 6'h00;
    end else begin
      cal_q <= cal_start | (cal_q & ~cal_done);
      pend_q <= conv_start | (pend_q & ~conv_done & ~conv_abort);
      hw_q <= wr_ctrl ? reg_wdata[6] : hw_q;
      cont_q <= wr_cal ? reg_wdata[3] : cont_q;
      avg_q <= wr_cal ? reg_wdata[2] : avg_q;
      fail_q <= (cal_q & (reg_wr | stop_mode | hw_q)) | (fail_q & ~(wr_cal & reg_wdata[6]));
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_read_idle: assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  chk_cal_bits: assert property (reg_rd && reg_addr == 4'h1 |=>
    reg_rdata[7:6] == {$past(cal_q), $past(fail_q)}) else $error("calibration bits wrong");
  chk_vref_code: assert property (wr_ctrl |=> ##1 vref_select ==
    ($past(reg_wdata[1:0], 2) == 2'h3 ? 2'h0 : $past(reg_wdata[1:0], 2))) else $error("reference select wrong");
  chk_cal_launch: assert property (wr_cal && reg_wdata[7] && !cal_q && !cal_start |=> cal_start)
    else $error("calibration not launched");
  chk_cal_abort: assert property (cal_start && pend_q |-> conv_abort) else $error("conversion not aborted");
  chk_sw_trigger: assert property (reg_wr && reg_addr == 4'hC && !hw_q && !cal_q && !cal_start |=>
    conv_start) else $error("software trigger lost");
  chk_cont_repeat: assert property (conv_done && pend_q && cont_q && !cal_q && !reg_wr |=> conv_start)
    else $error("continuous run stopped");
  chk_single_stop: assert property (conv_done && pend_q && !cont_q && !avg_q && !reg_wr |=>
    !conv_start) else $error("single conversion repeated");
  chk_strobe_cause: assert property (result_strobe |-> $past(conv_done)) else $error("stray result strobe");
endmodule // acc_ctrl_monitor

bind acc_ctrl acc_ctrl_monitor acc_ctrl_monitor_i (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_trigger(hw_trigger),
  .stop_mode(stop_mode), .conv_start(conv_start), .conv_abort(conv_abort), .conv_done(conv_done),
  .conv_raw(conv_raw), .cal_start(cal_start), .cal_done(cal_done), .vref_select(vref_select),
  .plus_gain_core(plus_gain_core), .result_strobe(result_strobe));

// ===== test/acc_ctrl_tb.sv
// Self-checking testbench for the converter control block
`timescale 1ns/100ps
module acc_ctrl_tb;
  reg clk_sys, reset, reg_wr, reg_rd, hw_trigger, stop_mode, conv_done, cal_done, got;
  reg [3:0] reg_addr;
  reg [7:0] reg_wdata, rd_v;
  reg [15:0] conv_raw, raw, ofs, res;
  reg [31:0] seed, sm;
  reg signed [19:0] dv, ov;
  reg [2:0] md;
  wire [7:0] reg_rdata;
  wire conv_start, conv_abort, cal_start, result_strobe;
  wire [1:0] vref_select;
  wire [15:0] plus_gain_core;
  integer err_total, comparisons, i, j, k;

  acc_ctrl acc_ctrl_i (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_trigger(hw_trigger), .stop_mode(stop_mode),
    .conv_start(conv_start), .conv_abort(conv_abort), .conv_done(conv_done), .conv_raw(conv_raw),
    .cal_start(cal_start), .cal_done(cal_done), .vref_select(vref_select), .plus_gain_core(plus_gain_core),
    .result_strobe(result_strobe));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [31:0] rnd(input [31:0] s);
    reg [31:0] x;
    begin
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      rnd = x ^ (x << 5);
    end
  endfunction
  // Result width per mode code: 16, 16, 12, 13, 10, 11, 8, 9
  function integer nb(input [2:0] m);
    begin
      nb = m < 2 ? 16 : 14 - 2 * (m >> 1) + m[0];
    end
  endfunction
  // Odd mode codes are signed differential results
  function [15:0] sat(input signed [19:0] v, input [2:0] m);
    reg signed [19:0] hi, lo;
    begin
      hi = m[0] ? (20'sh00001 <<< (nb(m) - 1)) - 20'sh00001 : (20'sh00001 <<< nb(m)) - 20'sh00001;
      lo = m[0] ? -(20'sh00001 <<< (nb(m) - 1)) : 20'sh00000;
      sat = v > hi ? hi[15:0] : (v < lo ? lo[15:0] : v[15:0]);
    end
  endfunction
  // Limits 16'h4000 and 16'hC000, ordered so the first is the lower one
  function hit(input [15:0] r, input en, input gt, input ren);
    begin
      if (!en) hit = 1'b1;
      else if (!ren) hit = gt ? r >= 16'h4000 : r < 16'h4000;
      else hit = gt ? (r >= 16'h4000 && r <= 16'hC000) : (r < 16'h4000 || r > 16'hC000);
    end
  endfunction
  task chk(input [15:0] seen, input [15:0] ev);
    begin
      comparisons = comparisons + 1;
      if (seen !== ev) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, seen, ev);
      end
    end
  endtask
  task wr(input [3:0] ad, input [7:0] d);
    begin
      @(posedge clk_sys);
      reg_wr <= 1'b1;
      reg_addr <= ad;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] ad);
    begin
      @(posedge clk_sys);
      reg_rd <= 1'b1;
      reg_addr <= ad;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata;
    end
  endtask
  task rres;
    begin
      rd(4'hA);
      res[15:8] = rd_v;
      rd(4'hB);
      res[7:0] = rd_v;
    end
  endtask
  // One conversion; w waits for the start pulse, the raw lines scramble once released
  task one(input [15:0] v, input w);
    begin
      // Step past the edge so a start pulse launched on it is already visible
      #1 j = 0;
      while (w && conv_start !== 1'b1 && j < 20) begin
        @(posedge clk_sys);
        #1 j = j + 1;
      end
      chk(j < 20, 1);
      @(posedge clk_sys);
      conv_done <= 1'b1;
      conv_raw <= v;
      @(posedge clk_sys);
      conv_done <= 1'b0;
      conv_raw <= ~v;
      #1 got = result_strobe;
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d, mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total = err_total + 1;
    test_done;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {reset, reg_wr, reg_rd, hw_trigger, stop_mode, conv_done, cal_done} = 7'h40;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    conv_raw = 16'h0000;
    seed = 32'h98009A8F;
    err_total = 0;
    comparisons = 0;
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    #1 chk(plus_gain_core, 16'h8000);
    for (i = 0; i < 16; i = i + 1) begin
      rd(i[3:0]);
      chk(rd_v, i == 4 ? 8'h80 : 8'h00);
    end
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h0, i[7:0]);
      repeat (2) @(posedge clk_sys);
      #1 chk(vref_select, i[1:0] == 2'h3 ? 2'h0 : i[1:0]);
    end
    wr(4'h4, 8'h40);
    repeat (2) @(posedge clk_sys);
    #1 chk(plus_gain_core, 16'h4000);
    wr(4'hC, 8'h00);
    one(16'h1235, 1'b1);
    rres;
    chk(res, 16'h091A);
    wr(4'h4, 8'h80);
    for (i = 0; i < 12; i = i + 1) begin
      seed = rnd(seed);
      {ofs, raw} = seed;
      case (i)
        0: {ofs, raw} = 32'h0064000A;
        1: {ofs, raw} = 32'hFF007FF0;
        2: {ofs, raw} = 32'hFF00FFF0;
        3: {ofs, raw} = 32'h01008010;
        default: ;
      endcase
      wr(4'h2, ofs[15:8]);
      wr(4'h3, ofs[7:0]);
      md = i < 4 ? {2'b00, i[0]} : i[2:0];
      wr(4'hC, {5'h00, md});
      one(raw, 1'b1);
      chk(got, 1);
      rres;
      ov = $signed({{4{ofs[15]}}, ofs}) >>> (16 - nb(md));
      dv = {{4{md[0] & raw[15]}}, raw} - ov;
      chk(res, sat(dv, md));
    end
    wr(4'h2, 8'h00);
    wr(4'h3, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(4'h1, 8'h04 | i[7:0]);
      wr(4'hC, 8'h00);
      sm = 0;
      for (k = 0; k < (4 << i); k = k + 1) begin
        seed = rnd(seed);
        one(seed[15:0], 1'b1);
        sm = sm + seed[15:0];
        chk(got, k == (4 << i) - 1);
      end
      chk(conv_start, 0);
      rres;
      sm = sm >> (2 + i);
      chk(res, sm[15:0]);
    end
    wr(4'h1, 8'h08);
    wr(4'hC, 8'h00);
    one(16'h1111, 1'b1);
    chk(got, 1);
    one(16'h2222, 1'b1);
    wr(4'h1, 8'h00);
    one(16'h3333, 1'b0);
    chk(conv_start, 0);
    rres;
    chk(res, 16'h3333);
    wr(4'h0, 8'h40);
    @(posedge clk_sys);
    hw_trigger <= 1'b1;
    @(posedge clk_sys);
    hw_trigger <= 1'b0;
    one(16'h0ABC, 1'b1);
    chk(got, 1);
    wr(4'h6, 8'h40);
    wr(4'h7, 8'h00);
    wr(4'h8, 8'hC0);
    wr(4'h9, 8'h00);
    for (i = 0; i < 24; i = i + 1) begin
      seed = rnd(seed);
      case (seed[2:0])
        3'h0: raw = 16'h4000;
        3'h1: raw = 16'hC000;
        3'h2: raw = 16'h3FFF;
        3'h3: raw = 16'hC001;
        default: raw = seed[31:16];
      endcase
      wr(4'h0, {2'b00, i < 20, i[0], i[1], 3'h0});
      wr(4'hC, 8'h00);
      one(raw, 1'b1);
      chk(got, hit(raw, i < 20, i[0], i[1]));
    end
    wr(4'h0, 8'h00);
    wr(4'hC, 8'h00);
    @(posedge clk_sys);
    wr(4'h1, 8'h80);
    #1 chk({cal_start, conv_abort}, 2'b11);
    rd(4'h1);
    chk(rd_v[7], 1);
    // Pass 0 ends cleanly; the others break calibration by a write, the trigger select, stop mode
    for (i = 0; i < 4; i = i + 1) begin
      if (i > 0) begin
        wr(4'h1, 8'h80);
        @(posedge clk_sys);
      end
      case (i)
        1: wr(4'h3, 8'h5A);
        2: wr(4'h0, 8'h40);
        3: begin
          @(posedge clk_sys);
          stop_mode <= 1'b1;
          @(posedge clk_sys);
          stop_mode <= 1'b0;
        end
        default: ;
      endcase
      @(posedge clk_sys);
      cal_done <= 1'b1;
      @(posedge clk_sys);
      cal_done <= 1'b0;
      wr(4'h0, 8'h00);
      rd(4'h1);
      chk(rd_v[7:6], {1'b0, i > 0});
      wr(4'h1, 8'h00);
      rd(4'h1);
      chk(rd_v[6], i > 0);
      wr(4'h1, 8'h40);
      rd(4'h1);
      chk(rd_v[6], 0);
    end
    test_done;
  end
endmodule // acc_ctrl_tb
